// *** rtl/lane_delay_align_crossbar.sv ***
/*
 * Multiframe alignment, latency measurement and lane crossbar for a
 * four-lane serial receiver, with a 16-word FIFO on the aligned data.
 * Assumes lane data and boundary marks arrive on the processing clock;
 * the sync reference pin is asynchronous and is synchronised here.
 */
// Functional notes
// - Measure local-to-last-boundary latency, readable at 0x302
// - Latency wraps below clocks per multiframe
// - Window above ten clocks cannot be absorbed
// - Release delay modulo multiframe, units by subclass
// - Four 3-bit lane source fields, two registers
// - Logical lane takes selected physical lane; identity reset
// - Latency counted in processing clocks, eight bits
// - Frames per processing clock equal four over F
// - Clocks per multiframe equal K over that
`timescale 1ns/100ps
module lane_delay_align_crossbar
(
  input  wire logic                              clk_in,
  input  wire logic                              rst_b_in,
  input  wire logic                              reg_wr_en_in,
  input  wire logic [11:0]                       reg_addr_in,
  input  wire logic [7:0]                        reg_wr_data_in,
  output logic      [7:0]                        reg_rd_data_out,
  input  wire logic [5:0]                        frames_per_multiframe_in,
  input  wire logic [2:0]                        octets_per_frame_in,
  input  wire logic [7:0]                        multiframe_release_delay_in,
  input  wire logic [4:0]                        variable_delay_window_in,
  input  wire logic                              sysref_in,
  input  wire logic [lane_align_pkg::DATA_W-1:0] serial_lane_data_in,
  input  wire logic [lane_align_pkg::LANES-1:0]  lane_boundary_in,
  output logic                                   lane_ready_out,
  output logic                                   local_receive_multiframe_clock_out,
  output logic                                   aligned_out,
  output logic                                   window_too_large_out,
  output logic      [lane_align_pkg::DATA_W-1:0] aligned_data_out,
  output logic                                   aligned_valid_out,
  input  wire logic                              aligned_ready_in
);
  typedef enum {IDLE, ARMED, MEASURE, HOLD, RUN} sync_state_t;

  localparam int CW = lane_align_pkg::CNT_W;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [CW-1:0] clocks_per_mf(input logic [5:0] k, input logic [2:0] f);
    logic [CW-1:0] fpp;
    fpp = lane_align_pkg::OCTETS_PER_PCLK / CW'(f);
    clocks_per_mf = CW'(k) / fpp;
  endfunction

  function automatic logic [lane_align_pkg::LANE_W-1:0] lane_pick(
    input logic [lane_align_pkg::DATA_W-1:0] d, input logic [2:0] sel);
    lane_pick = (sel < 3'(lane_align_pkg::LANES)) ?
                d[sel[1:0]*lane_align_pkg::LANE_W +: lane_align_pkg::LANE_W] : '0;
  endfunction

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0]    sync_q, sync_d, link_q, link_d, sub_q, sub_d;
  logic [7:0]    lat_q, lat_d, xlo_q, xlo_d, xhi_q, xhi_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [3:0]    seen_q, seen_d;
  sync_state_t   st_q, st_d;
  logic          sr_meta_q, sr_sync_q, sr_prev_q;
  logic [CW-1:0] pcpm, rel_phase, fpp;
  logic          sync_event, all_seen;
  logic [3:0]    lb_mapped;
  logic [2:0]    src [lane_align_pkg::LANES];
  logic [lane_align_pkg::DATA_W-1:0] xbar_data;

  fifo_link_if fl ();

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sr_meta_q <= 1'b0;
      sr_sync_q <= 1'b0;
      sr_prev_q <= 1'b0;
    end
    else
    begin
      sr_meta_q <= sysref_in;
      sr_sync_q <= sr_meta_q;
      sr_prev_q <= sr_sync_q;
    end
  end

  // ****************************************
  // Crossbar and multiframe arithmetic
  // ****************************************
  always_comb
  begin
    src[0] = xlo_q[lane_align_pkg::SRC_LO_POS +: lane_align_pkg::SEL_W];
    src[1] = xlo_q[lane_align_pkg::SRC_HI_POS +: lane_align_pkg::SEL_W];
    src[2] = xhi_q[lane_align_pkg::SRC_LO_POS +: lane_align_pkg::SEL_W];
    src[3] = xhi_q[lane_align_pkg::SRC_HI_POS +: lane_align_pkg::SEL_W];
    for (int i = 0; i < lane_align_pkg::LANES; i++)
    begin
      xbar_data[i*lane_align_pkg::LANE_W +: lane_align_pkg::LANE_W] =
        lane_pick(serial_lane_data_in, src[i]);
      lb_mapped[i] = (src[i] < 3'(lane_align_pkg::LANES)) ? lane_boundary_in[src[i][1:0]] : 1'b0;
    end
    fpp  = lane_align_pkg::OCTETS_PER_PCLK / CW'(octets_per_frame_in);
    pcpm = clocks_per_mf(frames_per_multiframe_in, octets_per_frame_in);
    // Subclass 1 delay is in frames modulo K, subclass 0 in clocks modulo the multiframe
    if (sub_q[lane_align_pkg::SUBCLASS_BIT])
    begin
      rel_phase = (multiframe_release_delay_in % CW'(frames_per_multiframe_in)) / fpp;
    end
    else
    begin
      rel_phase = multiframe_release_delay_in % pcpm;
    end
  end

  // ****************************************
  // Register file and sync machine
  // ****************************************
  always_comb
  begin
    sync_d = sync_q;
    link_d = link_q;
    sub_d  = sub_q;
    xlo_d  = xlo_q;
    xhi_d  = xhi_q;
    lat_d  = lat_q;
    st_d   = st_q;
    seen_d = seen_q;
    sync_event = (st_q == ARMED) &&
                 (!sub_q[lane_align_pkg::SUBCLASS_BIT] || (sr_sync_q && !sr_prev_q));
    all_seen = &(seen_q | lb_mapped);
    // Counter ticks in processing clocks and wraps at one multiframe
    cnt_d = (sync_event || cnt_q >= pcpm - 1'b1) ? '0 : cnt_q + 1'b1;
    unique case (st_q)
      IDLE:
      begin
        if (sync_q[lane_align_pkg::SYNC_ENABLE_BIT] && sync_q[lane_align_pkg::SYNC_ARM_BIT] &&
            sync_q[lane_align_pkg::SYNC_ONESHOT_BIT])
        begin
          st_d = ARMED;
        end
      end
      ARMED:
      begin
        if (sync_event)
        begin
          st_d   = MEASURE;
          seen_d = '0;
          sync_d[lane_align_pkg::SYNC_ARM_BIT] = 1'b0;
        end
      end
      MEASURE:
      begin
        if (link_q[lane_align_pkg::LINK_EN_BIT])
        begin
          seen_d = seen_q | lb_mapped;
          if (all_seen)
          begin
            lat_d = 8'(cnt_q);
            st_d  = HOLD;
          end
        end
      end
      HOLD:
      begin
        if (cnt_q == rel_phase)
        begin
          st_d = RUN;
        end
      end
      RUN:
      begin
        if (!link_q[lane_align_pkg::LINK_EN_BIT])
        begin
          st_d = IDLE;
        end
      end
    endcase
    if (reg_wr_en_in)
    begin
      unique case (reg_addr_in)
        lane_align_pkg::ADDR_SYNC:     sync_d = reg_wr_data_in;
        lane_align_pkg::ADDR_LINK_EN:  link_d = reg_wr_data_in;
        lane_align_pkg::ADDR_SUBCLASS: sub_d  = reg_wr_data_in;
        lane_align_pkg::ADDR_XBAR_LO:  xlo_d  = {2'h0, reg_wr_data_in[5:0] & lane_align_pkg::XBAR_MASK};
        lane_align_pkg::ADDR_XBAR_HI:  xhi_d  = {2'h0, reg_wr_data_in[5:0] & lane_align_pkg::XBAR_MASK};
        default:                       sync_d = sync_d;
      endcase
    end
    unique case (reg_addr_in)
      lane_align_pkg::ADDR_SYNC:     rd_d = sync_q;
      lane_align_pkg::ADDR_LINK_EN:  rd_d = link_q;
      lane_align_pkg::ADDR_SUBCLASS: rd_d = sub_q;
      lane_align_pkg::ADDR_LATENCY:  rd_d = lat_q;
      lane_align_pkg::ADDR_XBAR_LO:  rd_d = xlo_q;
      lane_align_pkg::ADDR_XBAR_HI:  rd_d = xhi_q;
      default:                       rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sync_q <= lane_align_pkg::SYNC_RESET;
      link_q <= lane_align_pkg::LINK_EN_RESET;
      sub_q  <= lane_align_pkg::SUBCLASS_RESET;
      xlo_q  <= lane_align_pkg::XBAR_LO_RESET;
      xhi_q  <= lane_align_pkg::XBAR_HI_RESET;
      lat_q  <= 8'h00;
      rd_q   <= 8'h00;
      cnt_q  <= '0;
      seen_q <= '0;
      st_q   <= IDLE;
    end
    else
    begin
      sync_q <= sync_d;
      link_q <= link_d;
      sub_q  <= sub_d;
      xlo_q  <= xlo_d;
      xhi_q  <= xhi_d;
      lat_q  <= lat_d;
      rd_q   <= rd_d;
      cnt_q  <= cnt_d;
      seen_q <= seen_d;
      st_q   <= st_d;
    end
  end

  // ****************************************
  // Output FIFO and outputs
  // ****************************************
  assign fl.push_data   = xbar_data;
  assign fl.push_valid  = (st_q == RUN);
  assign fl.pop_ready   = aligned_ready_in;

  lane_fifo #(.WIDTH(lane_align_pkg::DATA_W), .DEPTH(lane_align_pkg::FIFO_DEPTH)) u_fifo
  (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .link     (fl)
  );

  assign lane_ready_out       = fl.push_ready && (st_q == RUN);
  assign aligned_data_out     = fl.pop_data;
  assign aligned_valid_out    = fl.pop_valid;
  assign reg_rd_data_out      = rd_q;
  assign aligned_out          = (st_q == HOLD) || (st_q == RUN);
  assign local_receive_multiframe_clock_out = (cnt_q == '0);
  assign window_too_large_out = variable_delay_window_in > lane_align_pkg::MAX_WINDOW;

  // ****************************************
  // Checks
  // ****************************************
  property p_lat_wrap;
    @(posedge clk_in) disable iff (!rst_b_in) (st_q == MEASURE) && (st_d == HOLD) |=> lat_q < 8'(pcpm);
  endproperty
  a_lat_wrap: assert property (p_lat_wrap) else $error("latency beyond multiframe");

  property p_lat_capture;
    @(posedge clk_in) disable iff (!rst_b_in) (st_q == MEASURE) && (st_d == HOLD) |=> lat_q == 8'($past(cnt_q));
  endproperty
  a_lat_capture: assert property (p_lat_capture) else $error("latency not captured");

  property p_lat_hold;
    @(posedge clk_in) disable iff (!rst_b_in) (st_q != MEASURE) |=> $stable(lat_q);
  endproperty
  a_lat_hold: assert property (p_lat_hold) else $error("latency changed outside alignment");

  property p_cnt_wrap;
    @(posedge clk_in) disable iff (!rst_b_in) (cnt_q >= pcpm - 1'b1) |=> cnt_q == '0;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("multiframe count did not wrap");

  property p_sync_rearm;
    @(posedge clk_in) disable iff (!rst_b_in) sync_event && !reg_wr_en_in |=> !sync_q[lane_align_pkg::SYNC_ARM_BIT];
  endproperty
  a_sync_rearm: assert property (p_sync_rearm) else $error("arm bit not cleared");

  property p_sysref_gate;
    @(posedge clk_in) disable iff (!rst_b_in)
      (st_q == ARMED) && sub_q[lane_align_pkg::SUBCLASS_BIT] && !(sr_sync_q && !sr_prev_q) |=> st_q == ARMED;
  endproperty
  a_sysref_gate: assert property (p_sysref_gate) else $error("sync without reference edge");

  property p_window;
    @(posedge clk_in) disable iff (!rst_b_in)
      window_too_large_out == (variable_delay_window_in > lane_align_pkg::MAX_WINDOW);
  endproperty
  a_window: assert property (p_window) else $error("window flag wrong");

  property p_release;
    @(posedge clk_in) disable iff (!rst_b_in) (st_q == HOLD) && (cnt_q == rel_phase) |=> st_q == RUN;
  endproperty
  a_release: assert property (p_release) else $error("release missed");

  property p_xbar0;
    @(posedge clk_in) disable iff (!rst_b_in)
      src[0] < 3'h4 |-> xbar_data[31:0] == serial_lane_data_in[src[0][1:0]*32 +: 32];
  endproperty
  a_xbar0: assert property (p_xbar0) else $error("lane 0 mapped wrong");

  c_aligned: cover property (@(posedge clk_in) disable iff (!rst_b_in) st_q == MEASURE ##[1:100] st_q == HOLD);
  c_run: cover property (@(posedge clk_in) disable iff (!rst_b_in) st_q == HOLD ##1 st_q == RUN);
  c_stall: cover property (@(posedge clk_in) disable iff (!rst_b_in) aligned_valid_out && !aligned_ready_in);
endmodule

// *** rtl/lane_align_pkg.sv ***
/*
 * Constants shared by the lane alignment block and its output FIFO:
 * register offsets, field positions, reset values and widths.
 * Assumes a 12-bit register address and 8-bit register data.
 */
package lane_align_pkg;
  localparam int          LANES         = 4;
  localparam int          LANE_W        = 32;
  localparam int          DATA_W        = LANES * LANE_W;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          SEL_W         = 3;
  localparam int          CNT_W         = 8;
  localparam logic [11:0] ADDR_SYNC     = 12'h03A;
  localparam logic [11:0] ADDR_LINK_EN  = 12'h300;
  localparam logic [11:0] ADDR_SUBCLASS = 12'h301;
  localparam logic [11:0] ADDR_LATENCY  = 12'h302;
  localparam logic [11:0] ADDR_XBAR_LO  = 12'h308;
  localparam logic [11:0] ADDR_XBAR_HI  = 12'h309;
  localparam int          SYNC_ONESHOT_BIT = 0;
  localparam int          SYNC_ARM_BIT     = 6;
  localparam int          SYNC_ENABLE_BIT  = 7;
  localparam int          LINK_EN_BIT      = 0;
  localparam int          SUBCLASS_BIT     = 0;
  localparam int          SRC_LO_POS       = 0;
  localparam int          SRC_HI_POS       = 3;
  localparam logic [7:0]  SYNC_RESET     = 8'h00;
  localparam logic [7:0]  LINK_EN_RESET  = 8'h00;
  localparam logic [7:0]  SUBCLASS_RESET = 8'h00;
  localparam logic [7:0]  XBAR_LO_RESET  = 8'h08;
  localparam logic [7:0]  XBAR_HI_RESET  = 8'h1A;
  localparam logic [5:0]  XBAR_MASK      = 6'h3F;
  localparam logic [4:0]  MAX_WINDOW     = 5'h0A;
  localparam logic [7:0]  OCTETS_PER_PCLK = 8'h04;
  localparam int          PCLK_PERIOD_NS = 10;
endpackage

// *** rtl/fifo_link_if.sv ***
/*
 * Valid/ready carrier between the alignment logic and its FIFO.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface fifo_link_if;
  logic [lane_align_pkg::DATA_W-1:0] push_data;
  logic                              push_valid;
  logic                              push_ready;
  logic [lane_align_pkg::DATA_W-1:0] pop_data;
  logic                              pop_valid;
  logic                              pop_ready;
  modport producer (output push_data, output push_valid, input push_ready,
                    input pop_data, input pop_valid, output pop_ready);
  modport fifo (input push_data, input push_valid, output push_ready,
                output pop_data, output pop_valid, input pop_ready);
endinterface

// *** rtl/lane_fifo.sv ***
/*
 * Synchronous FIFO with a registered output stage.
 * Assumes one clock; read data always come out of a register.
 */
`timescale 1ns/100ps
module lane_fifo
#(
  parameter int WIDTH = 128,
  parameter int DEPTH = 16
)
(
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  fifo_link_if.fifo link
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic [WIDTH-1:0] out_q, out_d;
  logic             ov_q, ov_d;
  logic             push, pop;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    push = link.push_valid && (cnt_q != (AW+1)'(DEPTH));
    pop  = (cnt_q != '0) && (!ov_q || link.pop_ready);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    out_d = pop ? mem_q[rd_q] : out_q;
    ov_d = pop ? 1'b1 : (link.pop_ready ? 1'b0 : ov_q);
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      out_q <= '0;
      ov_q  <= 1'b0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      ov_q  <= ov_d;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem_q[wr_q] <= link.push_data;
    end
  end

  assign link.push_ready = (cnt_q != (AW+1)'(DEPTH));
  assign link.pop_data   = out_q;
  assign link.pop_valid  = ov_q;

  // ****************************************
  // Checks
  // ****************************************
  property p_fifo_count_bound;
    @(posedge clk_in) disable iff (!rst_b_in) cnt_q <= (AW+1)'(DEPTH);
  endproperty
  a_fifo_count_bound: assert property (p_fifo_count_bound) else $error("fifo count beyond depth");

  property p_fifo_hold;
    @(posedge clk_in) disable iff (!rst_b_in)
      link.pop_valid && !link.pop_ready |=> link.pop_valid && $stable(link.pop_data);
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("fifo output changed while stalled");

  c_fifo_full: cover property (@(posedge clk_in) disable iff (!rst_b_in) !link.push_ready);
endmodule

// *** verification/lane_tx_model.sv ***
/*
 * Behavioural transmitter facing the alignment block: four lanes of data,
 * one multiframe boundary per lane at a set delay, and the sync reference pin.
 * Assumes the local multiframe clock of the device is visible to it.
 */
`timescale 1ns/100ps
module lane_tx_model
(
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic         mf_clk_in,
  input  wire logic [11:0]  delay_in,
  input  wire logic         sysref_req_in,
  output logic      [127:0] lane_data_out,
  output logic      [3:0]   boundary_out,
  output logic              sysref_out
);
  // ****************************************
  // Delay line and data counter
  // ****************************************
  logic [7:0]  hist_q;
  logic [23:0] cnt_q;
  logic [1:0]  ref_q;
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      hist_q <= 8'h00;
      cnt_q  <= 24'h000000;
      ref_q  <= 2'h0;
    end
    else
    begin
      hist_q <= {hist_q[6:0], mf_clk_in};
      cnt_q  <= cnt_q + 24'h000001;
      ref_q  <= {ref_q[0], sysref_req_in};
    end
  end
  // Lane delays stay within 2..7 clocks, a spread inside the window limit
  always_comb
  begin
    for (int n = 0; n < 4; n++)
    begin
      lane_data_out[32*n +: 32] = {8'(n), cnt_q};
      boundary_out[n]           = hist_q[delay_in[3*n +: 3] - 3'h1];
    end
  end
  // One rising reference edge per request, after arming
  assign sysref_out = |ref_q;
endmodule

// *** verification/lane_delay_align_crossbar_bench.sv ***
/*
 * Self-checking bench for the lane alignment block with its FIFO.
 * Assumes K and F pairs that give eight processing clocks per multiframe.
 */
`timescale 1ns/100ps
module lane_delay_align_crossbar_bench;
  logic         clk_in, rst_b_in, wr_en, rd_req, ready, sysref_req, chk_data, chk_phase, last_rdy;
  logic [11:0]  addr, dly_vec, src_vec;
  logic [7:0]   wdata, rdata, rel_delay, last_lat, exp_ph;
  logic [4:0]   window;
  logic         lane_ready, mf_clk, aligned, too_large, avalid, sysref;
  logic [127:0] adata, lane_data;
  logic [3:0]   boundary;
  logic [7:0]   exp_q[$];
  int           errors, checked, ph;
  logic [7:0]   rd_seen, min_dly, max_dly;
  logic [7:0]   lat_list[$];
  logic [5:0]   k_val;
  logic [2:0]   f_val;
  logic         hi_seen;
  localparam int PCPM = 8;

  lane_delay_align_crossbar i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_wr_en_in(wr_en),
    .reg_addr_in(addr), .reg_wr_data_in(wdata), .reg_rd_data_out(rdata), .frames_per_multiframe_in(k_val),
    .octets_per_frame_in(f_val), .multiframe_release_delay_in(rel_delay), .variable_delay_window_in(window),
    .sysref_in(sysref), .serial_lane_data_in(lane_data), .lane_boundary_in(boundary),
    .lane_ready_out(lane_ready), .local_receive_multiframe_clock_out(mf_clk), .aligned_out(aligned),
    .window_too_large_out(too_large), .aligned_data_out(adata), .aligned_valid_out(avalid),
    .aligned_ready_in(ready));
  lane_tx_model i_tx (.clk_in(clk_in), .rst_b_in(rst_b_in), .mf_clk_in(mf_clk), .delay_in(dly_vec),
    .sysref_req_in(sysref_req), .lane_data_out(lane_data), .boundary_out(boundary), .sysref_out(sysref));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk_in);
    wr_en = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    addr = a;
    rd_req = 1'b1;
    exp_q.push_back(e);
    @(negedge clk_in);
    rd_req = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic wait_for(input int which);
    int n;
    for (n = 0; n < 300 && !(which == 0 ? aligned === 1'b1 : mf_clk === 1'b1); n++)
      @(negedge clk_in);
    if (n == 300)
    begin
      errors++;
      $display("unexpected timeout waiting on %0d", which);
      report_and_stop();
    end
  endtask
  // One sync, link enable and latency readback with random lane map and delays
  task automatic run_sync(input logic sub, input logic keep_del);
    int lat;
    int ph_exp;
    lat = 0;
    chk_data = 1'b0;
    wr(lane_align_pkg::ADDR_LINK_EN, 8'h00);
    repeat (40) @(negedge clk_in);
    rd(lane_align_pkg::ADDR_LATENCY, last_lat);
    for (int i = 0; i < 4; i++)
    begin
      src_vec[3*i +: 3] = 3'($urandom_range(3));
      dly_vec[3*i +: 3] = 3'($urandom_range(7, 2));
    end
    for (int i = 0; i < 4; i++)
      if (int'(dly_vec[3*src_vec[3*i +: 3] +: 3]) > lat)
        lat = int'(dly_vec[3*src_vec[3*i +: 3] +: 3]);
    if (!keep_del)
      rel_delay = 8'($urandom_range(255));
    ph_exp = sub ? (int'(rel_delay) % int'(k_val)) / (4 / int'(f_val)) : int'(rel_delay) % PCPM;
    // Push starts one clock after the count meets the release phase
    exp_ph = 8'((ph_exp + 1) % PCPM);
    wr(lane_align_pkg::ADDR_XBAR_LO, {2'h0, src_vec[5:0]});
    wr(lane_align_pkg::ADDR_XBAR_HI, {2'h0, src_vec[11:6]});
    rd(lane_align_pkg::ADDR_XBAR_HI, {2'h0, src_vec[11:6]});
    wr(lane_align_pkg::ADDR_SUBCLASS, {7'h00, sub});
    wr(lane_align_pkg::ADDR_SYNC, 8'h01);
    wr(lane_align_pkg::ADDR_SYNC, 8'h81);
    wr(lane_align_pkg::ADDR_SYNC, 8'hC1);
    sysref_req = sub;
    @(negedge clk_in);
    sysref_req = 1'b0;
    repeat (20) @(negedge clk_in);
    rd(lane_align_pkg::ADDR_SYNC, 8'h81);
    wait_for(1);
    chk_phase = 1'b1;
    wr(lane_align_pkg::ADDR_LINK_EN, 8'h01);
    wait_for(0);
    rd(lane_align_pkg::ADDR_LATENCY, 8'(lat));
    lat_list.push_back(rd_seen);
    last_lat = 8'(lat);
    chk_data = 1'b1;
    repeat (20) @(negedge clk_in);
    ready = 1'b0;
    repeat (40) @(negedge clk_in);
    cmp("lane ready when full", 8'h00, 8'(lane_ready));
    cmp("valid while stalled", 8'h01, 8'(avalid));
    ready = 1'b1;
    repeat (30) @(negedge clk_in);
    $display("test sync subclass %0d done", sub);
  endtask

  // ****************************************
  // Result watchers
  // ****************************************
  always @(posedge clk_in)
    if (rd_req === 1'b1)
    begin
      #2;
      rd_seen = rdata;
      cmp("register read", exp_q.pop_front(), rdata);
    end
  always @(posedge clk_in)
    if (avalid === 1'b1 && ready === 1'b1 && chk_data === 1'b1)
      for (int i = 0; i < 4; i++)
        cmp("lane source", 8'(src_vec[3*i +: 3]), adata[32*i+24 +: 8]);
  always @(negedge clk_in)
  begin
    ph = (mf_clk === 1'b1) ? 0 : ph + 1;
    if (lane_ready === 1'b1 && last_rdy !== 1'b1 && chk_phase === 1'b1)
    begin
      cmp("release phase", exp_ph, 8'(ph));
      chk_phase = 1'b0;
    end
    last_rdy = lane_ready;
  end

  // ****************************************
  // Clock, reset and test sequence
  // ****************************************
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial
  begin
    {rst_b_in, wr_en, rd_req, sysref_req, chk_data, chk_phase, last_rdy} = 7'h00;
    {addr, dly_vec, src_vec} = {12'h000, 12'hFFF, 12'hD10};
    {wdata, rel_delay, last_lat, exp_ph} = 32'h00000000;
    window = 5'h06;
    {k_val, f_val} = {6'h20, 3'h1};
    ready = 1'b1;
    errors = 0;
    checked = 0;
    ph = 0;
    void'($urandom(54));
    repeat (10) @(negedge clk_in);
    rst_b_in = 1'b1;
    rd(lane_align_pkg::ADDR_SYNC, lane_align_pkg::SYNC_RESET);
    rd(lane_align_pkg::ADDR_LINK_EN, lane_align_pkg::LINK_EN_RESET);
    rd(lane_align_pkg::ADDR_SUBCLASS, lane_align_pkg::SUBCLASS_RESET);
    rd(lane_align_pkg::ADDR_XBAR_LO, lane_align_pkg::XBAR_LO_RESET);
    rd(lane_align_pkg::ADDR_XBAR_HI, lane_align_pkg::XBAR_HI_RESET);
    wr(lane_align_pkg::ADDR_LATENCY, 8'h5A);
    wr(12'h123, 8'hA5);
    rd(lane_align_pkg::ADDR_LATENCY, 8'h00);
    rd(12'h123, 8'h00);
    wr(lane_align_pkg::ADDR_XBAR_LO, 8'hFF);
    rd(lane_align_pkg::ADDR_XBAR_LO, 8'h3F);
    $display("test registers done");
    for (int w = 8; w < 13; w++)
    begin
      window = 5'(w);
      @(negedge clk_in);
      cmp("window flag", 8'(w > int'(lane_align_pkg::MAX_WINDOW)), 8'(too_large));
    end
    window = 5'h06;
    $display("test window done");
    for (int r = 0; r < 20; r++)
    begin
      k_val = r[0] ? 6'h10 : 6'h20;
      f_val = r[0] ? 3'h2 : 3'h1;
      run_sync(r[1], 1'b0);
    end
    // Readings that straddle the multiframe wrap move up by one multiframe
    hi_seen = 1'b0;
    foreach (lat_list[i])
      if (lat_list[i] >= 8'(PCPM - PCPM / 4))
        hi_seen = 1'b1;
    foreach (lat_list[i])
      if (hi_seen && lat_list[i] < 8'(PCPM / 4))
        lat_list[i] = lat_list[i] + 8'(PCPM);
    min_dly = 8'hFF;
    max_dly = 8'h00;
    foreach (lat_list[i])
    begin
      if (lat_list[i] < min_dly)
        min_dly = lat_list[i];
      if (lat_list[i] > max_dly)
        max_dly = lat_list[i];
    end
    window = 5'((max_dly + 8'h01) - (min_dly - 8'h01));
    rel_delay = 8'((int'(min_dly) - 1) % PCPM);
    k_val = 6'h20;
    f_val = 3'h1;
    @(negedge clk_in);
    cmp("derived window flag", 8'(window > lane_align_pkg::MAX_WINDOW), 8'(too_large));
    $display("test derived delays done");
    run_sync(1'b0, 1'b1);
    report_and_stop();
  end
endmodule
